//--- hdl/lfb_top.sv
// Legacy facility data link byte buffer: receive byte, match, transmit byte, stuffing
// How it works
// - Each received link bit shifts into the receive byte, first bit lands in lsb.
// - After eight received bits the receive-full status flag is set.
// - With its mask set, a full receive buffer pulls the interrupt pin low.
// - A received byte equal to either match byte sets the match flag.
// - With its mask set, a match pulls the interrupt pin low.
// - With destuff enabled, a zero after exactly five ones is dropped.
// - A zero after six or more ones is never dropped.
// - The transmit byte is sent as the link bits of the outgoing stream.
// - Transmit byte is serialised lsb first into the link bit slots.
// - After eight bits leave, the transmit-empty flag is set.
// - With its mask set, an empty transmit buffer pulls the interrupt pin low.
// - Without a rewrite, the old transmit byte is sent again.
// - With stuffing enabled, a zero is inserted after five ones in a row.
// - Transmit link takes one source only, legacy buffer or hdlc controller.
`timescale 1ns/100ps
`include "lfb_consts.svh"
module lfb_top (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic srst_i,
  // Register port
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wr_data_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rd_data_o,
  // Receive link bit timing
  input wire logic rx_link_bit_i,
  input wire logic rx_link_strobe_i,
  // Transmit link bit timing
  input wire logic tx_link_strobe_i,
  input wire logic tx_mf_boundary_i,
  input wire logic hdlc_tx_bit_i,
  output logic tx_link_bit_o,
  // Interrupt
  output logic int_n_o
);

  // ==========================================================
  // Receive path
  lfb_rx_if rx_bus ();

  assign rx_bus.line_bit = rx_link_bit_i;
  assign rx_bus.strobe = rx_link_strobe_i;

  lfb_rx_path u_rx_path (
    .sys_clk_i(sys_clk_i),
    .srst_i(srst_i),
    .rx(rx_bus.path)
  );

  // ==========================================================
  // Register file
  lfb_pkg::lfb_byte_t rx_link_match_one;
  lfb_pkg::lfb_byte_t next_rx_link_match_one;
  lfb_pkg::lfb_byte_t rx_link_match_two;
  lfb_pkg::lfb_byte_t next_rx_link_match_two;
  lfb_pkg::lfb_byte_t rx_link_byte;
  lfb_pkg::lfb_byte_t next_rx_link_byte;
  lfb_pkg::lfb_byte_t tx_link_byte;
  lfb_pkg::lfb_byte_t next_tx_link_byte;
  logic [7:0] ctrl;
  logic [7:0] next_ctrl;
  logic [7:0] status;
  logic [7:0] next_status;
  logic [7:0] mask;
  logic [7:0] next_mask;
  logic [7:0] rd_data;
  logic [7:0] next_rd_data;
  logic [7:0] set_bits;
  logic [7:0] clr_bits;
  logic rx_hit;
  logic tx_empty_ev;

  // Destuffer enable comes straight from the control register
  assign rx_bus.destuff_en = ctrl[`LFB_CTRL_DESTUFF];

  // Match against the freshly assembled byte, not the held one
  assign rx_hit = (rx_bus.rx_data == rx_link_match_one) || (rx_bus.rx_data == rx_link_match_two);

  // Register next values; a flag set in the same cycle as its clear-on-read survives
  always_comb begin
    next_rx_link_match_one = rx_link_match_one;
    next_rx_link_match_two = rx_link_match_two;
    next_rx_link_byte = rx_link_byte;
    next_tx_link_byte = tx_link_byte;
    next_ctrl = ctrl;
    next_mask = mask;
    next_rd_data = 8'h00;
    set_bits = 8'h00;
    clr_bits = 8'h00;
    if (wr_i) begin
      case (addr_i)
        `LFB_ADDR_MATCH_ONE: next_rx_link_match_one = wr_data_i;
        `LFB_ADDR_MATCH_TWO: next_rx_link_match_two = wr_data_i;
        `LFB_ADDR_TX_BYTE: next_tx_link_byte = wr_data_i;
        `LFB_ADDR_CTRL: next_ctrl = wr_data_i & `LFB_CTRL_USED;
        `LFB_ADDR_MASK: next_mask = wr_data_i & `LFB_ST_USED;
        default: next_ctrl = ctrl;
      endcase
    end
    if (rd_i) begin
      case (addr_i)
        `LFB_ADDR_MATCH_ONE: next_rd_data = rx_link_match_one;
        `LFB_ADDR_MATCH_TWO: next_rd_data = rx_link_match_two;
        `LFB_ADDR_RX_BYTE: next_rd_data = rx_link_byte;
        `LFB_ADDR_TX_BYTE: next_rd_data = tx_link_byte;
        `LFB_ADDR_CTRL: next_rd_data = ctrl;
        `LFB_ADDR_MASK: next_rd_data = mask;
        `LFB_ADDR_STATUS: begin
          next_rd_data = status;
          clr_bits = status;
        end
        default: next_rd_data = 8'h00;
      endcase
    end
    // Overwrites an unread byte; the host must keep up
    if (rx_bus.done) begin
      next_rx_link_byte = rx_bus.rx_data;
      set_bits[`LFB_ST_RX_FULL] = 1'b1;
      set_bits[`LFB_ST_MATCH] = rx_hit;
    end
    set_bits[`LFB_ST_TX_EMPTY] = tx_empty_ev;
    next_status = (status & ~clr_bits) | set_bits;
  end

  // Register storage
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      rx_link_match_one <= `LFB_RST_BYTE;
      rx_link_match_two <= `LFB_RST_BYTE;
      rx_link_byte <= `LFB_RST_BYTE;
      tx_link_byte <= `LFB_RST_BYTE;
      ctrl <= `LFB_RST_CTRL;
      mask <= `LFB_RST_MASK;
      status <= `LFB_RST_STATUS;
      rd_data <= 8'h00;
    end else begin
      rx_link_match_one <= next_rx_link_match_one;
      rx_link_match_two <= next_rx_link_match_two;
      rx_link_byte <= next_rx_link_byte;
      tx_link_byte <= next_tx_link_byte;
      ctrl <= next_ctrl;
      mask <= next_mask;
      status <= next_status;
      rd_data <= next_rd_data;
    end
  end

  assign rd_data_o = rd_data;

  // Shared active-low interrupt from masked sticky flags
  assign int_n_o = ~|(status & mask);

  // ==========================================================
  // Transmit serialiser
  lfb_pkg::lfb_tx_state_e tx_state;
  lfb_pkg::lfb_tx_state_e next_tx_state;
  lfb_pkg::lfb_byte_t tx_shreg;
  lfb_pkg::lfb_byte_t next_tx_shreg;
  lfb_pkg::lfb_byte_t tx_src;
  logic [2:0] tx_cnt;
  logic [2:0] next_tx_cnt;
  logic [2:0] tx_ones;
  logic [2:0] next_tx_ones;
  logic tx_bit;
  logic next_tx_bit;
  logic tx_slot_ok;
  logic tx_stuff_now;
  logic tx_legacy;

  assign tx_legacy = !ctrl[`LFB_CTRL_HDLC_TX];
  assign tx_stuff_now = ctrl[`LFB_CTRL_STUFF] && (tx_ones == `LFB_RUN_LIMIT);
  // Multiframe load holds a new byte back until the boundary strobe
  assign tx_slot_ok = !ctrl[`LFB_CTRL_MF_LOAD] || tx_mf_boundary_i;
  // A byte slot copies the register, so an unwritten register is simply resent
  assign tx_src = (tx_state == lfb_pkg::LFB_TX_WAIT_SLOT) ? tx_link_byte : tx_shreg;

  // Next bit on each framer request; the run of ones carries across byte slots
  always_comb begin
    next_tx_state = tx_state;
    next_tx_shreg = tx_shreg;
    next_tx_cnt = tx_cnt;
    next_tx_ones = tx_ones;
    next_tx_bit = tx_bit;
    tx_empty_ev = 1'b0;
    if (tx_link_strobe_i) begin
      if (!tx_legacy) begin
        next_tx_bit = hdlc_tx_bit_i;
        next_tx_state = lfb_pkg::LFB_TX_WAIT_SLOT;
        next_tx_cnt = 3'h0;
        next_tx_ones = 3'h0;
      end else if (tx_stuff_now) begin
        next_tx_bit = 1'b0;
        next_tx_ones = 3'h0;
      end else begin
        case (tx_state)
          lfb_pkg::LFB_TX_WAIT_SLOT: begin
            if (tx_slot_ok) begin
              next_tx_bit = tx_src[0];
              next_tx_shreg = {1'b0, tx_src[7:1]};
              next_tx_ones = tx_src[0] ? tx_ones + 3'h1 : 3'h0;
              next_tx_cnt = 3'h1;
              next_tx_state = lfb_pkg::LFB_TX_SHIFT;
            end else begin
              next_tx_bit = `LFB_IDLE_BIT;
              next_tx_ones = 3'h0;
            end
          end
          lfb_pkg::LFB_TX_SHIFT: begin
            next_tx_bit = tx_src[0];
            next_tx_shreg = {1'b0, tx_src[7:1]};
            next_tx_ones = tx_src[0] ? tx_ones + 3'h1 : 3'h0;
            if (tx_cnt == `LFB_BIT_LAST) begin
              next_tx_cnt = 3'h0;
              next_tx_state = lfb_pkg::LFB_TX_WAIT_SLOT;
              tx_empty_ev = 1'b1;
            end else begin
              next_tx_cnt = tx_cnt + 3'h1;
            end
          end
          default: begin
            next_tx_state = lfb_pkg::LFB_TX_WAIT_SLOT;
            next_tx_cnt = 3'h0;
          end
        endcase
      end
    end
  end

  // Serialiser storage
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      tx_state <= lfb_pkg::LFB_TX_WAIT_SLOT;
      tx_shreg <= `LFB_RST_BYTE;
      tx_cnt <= 3'h0;
      tx_ones <= 3'h0;
      tx_bit <= `LFB_IDLE_BIT;
    end else begin
      tx_state <= next_tx_state;
      tx_shreg <= next_tx_shreg;
      tx_cnt <= next_tx_cnt;
      tx_ones <= next_tx_ones;
      tx_bit <= next_tx_bit;
    end
  end

  assign tx_link_bit_o = tx_bit;

  // ==========================================================
  // Checks
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);

  sequence s_rx_byte_done;
    rx_bus.done;
  endsequence

  sequence s_tx_slot_start;
    tx_link_strobe_i && tx_legacy && !tx_stuff_now && (tx_state == lfb_pkg::LFB_TX_WAIT_SLOT) && tx_slot_ok;
  endsequence

  sequence s_tx_last_bit;
    tx_link_strobe_i && tx_legacy && !tx_stuff_now && (tx_state == lfb_pkg::LFB_TX_SHIFT)
      && (tx_cnt == `LFB_BIT_LAST);
  endsequence

  a_rx_full_flag: assert property (
    s_rx_byte_done |=> status[`LFB_ST_RX_FULL] && (rx_link_byte == $past(rx_bus.rx_data)))
    else $error("receive full flag or byte missing");

  a_rx_full_irq: assert property (
    s_rx_byte_done ##0 mask[`LFB_ST_RX_FULL] |=> !int_n_o)
    else $error("receive full interrupt not raised");

  a_match_flag: assert property (
    s_rx_byte_done ##0 rx_hit |=> status[`LFB_ST_MATCH])
    else $error("match flag not set");

  a_match_irq: assert property (
    s_rx_byte_done ##0 rx_hit ##0 mask[`LFB_ST_MATCH] |=> !int_n_o)
    else $error("match interrupt not raised");

  a_tx_lsb_first: assert property (
    s_tx_slot_start |=> tx_link_bit_o == $past(tx_link_byte[0]))
    else $error("transmit byte not sent lsb first");

  a_tx_empty_flag: assert property (
    s_tx_last_bit |=> status[`LFB_ST_TX_EMPTY] && (tx_state == lfb_pkg::LFB_TX_WAIT_SLOT))
    else $error("transmit empty flag not set");

  a_tx_empty_irq: assert property (
    s_tx_last_bit ##0 mask[`LFB_ST_TX_EMPTY] |=> !int_n_o)
    else $error("transmit empty interrupt not raised");

  a_tx_stuff_zero: assert property (
    tx_link_strobe_i && tx_legacy && tx_stuff_now |=> !tx_link_bit_o && (tx_ones == 3'h0))
    else $error("stuffed zero not inserted");

  a_tx_one_source: assert property (
    tx_link_strobe_i && !tx_legacy |=> (tx_link_bit_o == $past(hdlc_tx_bit_i))
      && (!status[`LFB_ST_TX_EMPTY] || ($past(status[`LFB_ST_TX_EMPTY]) && !$past(rd_i))))
    else $error("legacy data leaked onto hdlc transmit link");
endmodule

//--- pkg/lfb_consts.svh
// Register offsets, field positions and reset values of the legacy link byte buffer
`ifndef LFB_CONSTS_SVH
`define LFB_CONSTS_SVH

// ==========================================================
// Register offsets
`define LFB_ADDR_MATCH_TWO 8'h24
`define LFB_ADDR_RX_BYTE 8'h28
`define LFB_ADDR_MATCH_ONE 8'h29
`define LFB_ADDR_CTRL 8'h2A
`define LFB_ADDR_STATUS 8'h2B
`define LFB_ADDR_MASK 8'h2C
`define LFB_ADDR_TX_BYTE 8'h2D

// ==========================================================
// Control field positions
`define LFB_CTRL_DESTUFF 0
`define LFB_CTRL_HDLC_TX 1
`define LFB_CTRL_STUFF 4
`define LFB_CTRL_MF_LOAD 5
`define LFB_CTRL_USED 8'h33

// ==========================================================
// Status and mask field positions
`define LFB_ST_MATCH 2
`define LFB_ST_TX_EMPTY 3
`define LFB_ST_RX_FULL 4
`define LFB_ST_USED 8'h1C

// ==========================================================
// Reset values and counts
`define LFB_RST_BYTE 8'h00
`define LFB_RST_CTRL 8'h00
`define LFB_RST_MASK 8'h00
`define LFB_RST_STATUS 8'h00
`define LFB_RUN_LIMIT 3'h5
`define LFB_RUN_SAT 3'h6
`define LFB_BIT_LAST 3'h7
`define LFB_IDLE_BIT 1'b1

`endif

//--- pkg/lfb_pkg.sv
// Types shared by the legacy link byte buffer
package lfb_pkg;

  // ==========================================================
  // Transmit serialiser states
  typedef enum logic {
    LFB_TX_WAIT_SLOT,
    LFB_TX_SHIFT
  } lfb_tx_state_e;

  typedef logic [7:0] lfb_byte_t;

endpackage

//--- pkg/lfb_rx_if.sv
// Receive path bundle between the buffer top and its destuffing shifter
`timescale 1ns/100ps
interface lfb_rx_if;
  logic line_bit;
  logic strobe;
  logic destuff_en;
  lfb_pkg::lfb_byte_t rx_data;
  logic done;

  modport path (
    input line_bit,
    input strobe,
    input destuff_en,
    output rx_data,
    output done
  );

  modport top (
    output line_bit,
    output strobe,
    output destuff_en,
    input rx_data,
    input done
  );
endinterface

//--- hdl/lfb_rx_path.sv
// Receive shifter with zero destuffer for the legacy link byte buffer
`timescale 1ns/100ps
`include "lfb_consts.svh"
module lfb_rx_path (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic srst_i,
  // Link side bundle
  lfb_rx_if.path rx
);

  lfb_pkg::lfb_byte_t shreg;
  lfb_pkg::lfb_byte_t next_shreg;
  lfb_pkg::lfb_byte_t data;
  lfb_pkg::lfb_byte_t next_data;
  logic [2:0] cnt;
  logic [2:0] next_cnt;
  logic [2:0] ones;
  logic [2:0] next_ones;
  logic done;
  logic next_done;
  logic take;

  assign rx.rx_data = data;
  assign rx.done = done;

  // Next state: ones run count saturates so six or more never trigger a drop
  always_comb begin
    next_shreg = shreg;
    next_data = data;
    next_cnt = cnt;
    next_ones = ones;
    next_done = 1'b0;
    take = 1'b0;
    if (rx.strobe) begin
      if (rx.line_bit) begin
        next_ones = (ones == `LFB_RUN_SAT) ? `LFB_RUN_SAT : ones + 3'h1;
        take = 1'b1;
      end else begin
        next_ones = 3'h0;
        take = !(rx.destuff_en && (ones == `LFB_RUN_LIMIT));
      end
      if (take) begin
        next_shreg = {rx.line_bit, shreg[7:1]};
        if (cnt == `LFB_BIT_LAST) begin
          next_cnt = 3'h0;
          next_data = {rx.line_bit, shreg[7:1]};
          next_done = 1'b1;
        end else begin
          next_cnt = cnt + 3'h1;
        end
      end
    end
  end

  // Registers
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      shreg <= `LFB_RST_BYTE;
      data <= `LFB_RST_BYTE;
      cnt <= 3'h0;
      ones <= 3'h0;
      done <= 1'b0;
    end else begin
      shreg <= next_shreg;
      data <= next_data;
      cnt <= next_cnt;
      ones <= next_ones;
      done <= next_done;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);

  sequence s_stuffed_zero;
    rx.strobe && rx.destuff_en && !rx.line_bit && (ones == `LFB_RUN_LIMIT);
  endsequence

  sequence s_zero_after_long_run;
    rx.strobe && !rx.line_bit && (ones == `LFB_RUN_SAT);
  endsequence

  a_destuff_drops_zero: assert property (
    s_stuffed_zero |=> (cnt == $past(cnt)) && !done)
    else $error("stuffed zero was not removed");

  a_long_run_kept: assert property (
    s_zero_after_long_run |=> (cnt != $past(cnt)) || done)
    else $error("zero after six ones was removed");

  a_lsb_first: assert property (
    rx.strobe && take && (cnt == `LFB_BIT_LAST) |=> done && (data[7] == $past(rx.line_bit)))
    else $error("last received bit not in msb");
endmodule

//--- sim/lfb_framer_model.sv
// Framer-side bit timing model for the legacy link byte buffer
`timescale 1ns/100ps
module lfb_framer_model (
  // Clock
  input wire logic sys_clk_i,
  // Outgoing link bit observed
  input wire logic tx_link_bit_i,
  // Link bit timing driven
  output logic rx_link_bit_o,
  output logic rx_link_strobe_o,
  output logic tx_link_strobe_o,
  output logic tx_mf_boundary_o,
  output logic hdlc_tx_bit_o
);
  // ==========================================================
  // Idle levels
  // Set at time zero so the buffer never sees unknown timing
  initial begin
    rx_link_bit_o = 1'b0;
    rx_link_strobe_o = 1'b0;
    tx_link_strobe_o = 1'b0;
    tx_mf_boundary_o = 1'b0;
    hdlc_tx_bit_o = 1'b0;
  end

  // ==========================================================
  // Receive bits, first bit of the vector first
  // The line flips between strobes, so a sample off the strobe shows up as a wrong bit
  task automatic rx_bits(input logic [15:0] bits, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge sys_clk_i);
      rx_link_bit_o <= bits[i];
      rx_link_strobe_o <= 1'b1;
      @(posedge sys_clk_i);
      rx_link_bit_o <= ~bits[i];
      rx_link_strobe_o <= 1'b0;
    end
    repeat (3) @(posedge sys_clk_i);
  endtask

  // ==========================================================
  // Take n outgoing link bits; boundary marks only the first strobe
  task automatic tx_bits(input int n, input logic mf, input logic [15:0] hd, output logic [15:0] got);
    got = 16'h0000;
    for (int i = 0; i < n; i++) begin
      @(posedge sys_clk_i);
      tx_link_strobe_o <= 1'b1;
      tx_mf_boundary_o <= mf && (i == 0);
      hdlc_tx_bit_o <= hd[i];
      @(posedge sys_clk_i);
      tx_link_strobe_o <= 1'b0;
      tx_mf_boundary_o <= 1'b0;
      @(posedge sys_clk_i);
      got[i] = tx_link_bit_i;
      hdlc_tx_bit_o <= ~hd[i];
    end
  endtask
endmodule

//--- sim/lfb_top_bench.sv
// Self-checking bench of the legacy link byte buffer
`timescale 1ns/100ps
`include "lfb_consts.svh"
module lfb_top_bench;
  // ==========================================================
  // Signals and counters
  logic sys_clk, srst, wr, rd, rx_bit, rx_stb, tx_stb, tx_mf, hdlc_bit, tx_bit, int_n;
  logic [7:0] addr, wr_data, rd_data;
  logic [15:0] got;
  int fail_count = 0;
  int total_checks = 0;
  localparam logic [7:0] st_full = 8'h01 << `LFB_ST_RX_FULL;
  localparam logic [7:0] st_both = st_full | (8'h01 << `LFB_ST_MATCH);
  localparam logic [7:0] st_empty = 8'h01 << `LFB_ST_TX_EMPTY;

  // ==========================================================
  // Design and framer side
  lfb_top i_lfb_top (.sys_clk_i(sys_clk), .srst_i(srst), .addr_i(addr), .wr_data_i(wr_data),
    .wr_i(wr), .rd_i(rd), .rd_data_o(rd_data), .rx_link_bit_i(rx_bit), .rx_link_strobe_i(rx_stb),
    .tx_link_strobe_i(tx_stb), .tx_mf_boundary_i(tx_mf), .hdlc_tx_bit_i(hdlc_bit),
    .tx_link_bit_o(tx_bit), .int_n_o(int_n));
  lfb_framer_model i_lfb_framer_model (.sys_clk_i(sys_clk), .tx_link_bit_i(tx_bit),
    .rx_link_bit_o(rx_bit), .rx_link_strobe_o(rx_stb), .tx_link_strobe_o(tx_stb),
    .tx_mf_boundary_o(tx_mf), .hdlc_tx_bit_o(hdlc_bit));

  // 25 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  // ==========================================================
  // Compare and bus tasks
  task automatic check_reg(input logic [7:0] g, input logic [7:0] e);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED at %0t: value %h, expected %h", $time, g, e);
    end
  endtask

  task automatic check_pin(input logic g, input logic e);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED at %0t: pin %b, expected %b", $time, g, e);
    end
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    addr <= a;
    wr_data <= d;
    wr <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe; sampled mid-cycle, clear of both edges
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk);
    rd <= 1'b0;
    @(negedge sys_clk);
    check_reg(rd_data, e);
  endtask

  task automatic do_reset();
    srst <= 1'b1;
    repeat (8) @(posedge sys_clk);
    srst <= 1'b0;
  endtask

  // ==========================================================
  // Scenarios
  task automatic test_reset();
    logic [7:0] regs [8] = '{`LFB_ADDR_MATCH_TWO, `LFB_ADDR_RX_BYTE, `LFB_ADDR_MATCH_ONE,
      `LFB_ADDR_CTRL, `LFB_ADDR_STATUS, `LFB_ADDR_MASK, `LFB_ADDR_TX_BYTE, 8'h30};
    check_pin(int_n, 1'b1);
    check_pin(tx_bit, `LFB_IDLE_BIT);
    foreach (regs[i]) rd_chk(regs[i], `LFB_RST_BYTE);
    reg_wr(8'h30, 8'hFF);
    rd_chk(8'h30, 8'h00);
    reg_wr(`LFB_ADDR_CTRL, 8'hFF);
    rd_chk(`LFB_ADDR_CTRL, `LFB_CTRL_USED);
    reg_wr(`LFB_ADDR_CTRL, 8'h00);
    $display("test reset done");
  endtask

  // Byte table covers both match bytes and a miss
  task automatic test_rx_match();
    logic [7:0] bytes [3] = '{8'hA5, 8'h3C, 8'h00};
    logic [7:0] stat [3] = '{st_both, st_both, st_full};
    reg_wr(`LFB_ADDR_MATCH_ONE, 8'hA5);
    reg_wr(`LFB_ADDR_MATCH_TWO, 8'h3C);
    reg_wr(`LFB_ADDR_MASK, st_both);
    for (int i = 0; i < 3; i++) begin
      i_lfb_framer_model.rx_bits({8'h00, bytes[i]}, 8);
      check_pin(int_n, 1'b0);
      rd_chk(`LFB_ADDR_STATUS, stat[i]);
      check_pin(int_n, 1'b1);
      rd_chk(`LFB_ADDR_RX_BYTE, bytes[i]);
    end
    reg_wr(`LFB_ADDR_RX_BYTE, 8'hFF);
    reg_wr(`LFB_ADDR_MASK, 8'h00);
    i_lfb_framer_model.rx_bits(16'h003C, 8);
    check_pin(int_n, 1'b1);
    rd_chk(`LFB_ADDR_STATUS, st_both);
    rd_chk(`LFB_ADDR_RX_BYTE, 8'h3C);
    $display("test rx match done");
  endtask

  // Zero after five ones goes, zero after six ones stays
  task automatic test_destuff();
    do_reset();
    reg_wr(`LFB_ADDR_CTRL, 8'h01);
    i_lfb_framer_model.rx_bits(16'h001F, 9);
    rd_chk(`LFB_ADDR_RX_BYTE, 8'h1F);
    i_lfb_framer_model.rx_bits(16'h00BF, 8);
    rd_chk(`LFB_ADDR_RX_BYTE, 8'hBF);
    $display("test destuff done");
  endtask

  task automatic test_tx();
    do_reset();
    reg_wr(`LFB_ADDR_MASK, st_empty);
    reg_wr(`LFB_ADDR_TX_BYTE, 8'h5A);
    i_lfb_framer_model.tx_bits(8, 1'b0, 16'h0000, got);
    check_reg(got[7:0], 8'h5A);
    check_pin(int_n, 1'b0);
    rd_chk(`LFB_ADDR_STATUS, st_empty);
    i_lfb_framer_model.tx_bits(8, 1'b0, 16'h0000, got);
    check_reg(got[7:0], 8'h5A);
    reg_wr(`LFB_ADDR_TX_BYTE, 8'h96);
    i_lfb_framer_model.tx_bits(8, 1'b0, 16'h0000, got);
    check_reg(got[7:0], 8'h96);
    $display("test tx done");
  endtask

  // All-ones bytes: a stuffed zero after every five ones, run kept across bytes
  task automatic test_stuff();
    do_reset();
    reg_wr(`LFB_ADDR_CTRL, 8'h10);
    reg_wr(`LFB_ADDR_TX_BYTE, 8'hFF);
    i_lfb_framer_model.tx_bits(12, 1'b0, 16'h0000, got);
    check_reg(got[7:0], 8'hDF);
    check_reg({4'h0, got[11:8]}, 8'h07);
    $display("test stuff done");
  endtask

  // Slot waits for the boundary, then the other source takes the link
  task automatic test_source();
    do_reset();
    reg_wr(`LFB_ADDR_CTRL, 8'h20);
    reg_wr(`LFB_ADDR_TX_BYTE, 8'h0F);
    i_lfb_framer_model.tx_bits(3, 1'b0, 16'h0000, got);
    check_reg({5'h00, got[2:0]}, 8'h07);
    i_lfb_framer_model.tx_bits(8, 1'b1, 16'h0000, got);
    check_reg(got[7:0], 8'h0F);
    reg_wr(`LFB_ADDR_CTRL, 8'h02);
    i_lfb_framer_model.tx_bits(8, 1'b0, 16'h00C6, got);
    check_reg(got[7:0], 8'hC6);
    $display("test source done");
  endtask

  // ==========================================================
  // Verdict and main sequence
  task automatic give_verdict();
    $display("checks %0d, failures %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Bus idle at time zero, reset held for eight cycles
  initial begin
    srst = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wr_data = 8'h00;
    do_reset();
    test_reset();
    test_rx_match();
    test_destuff();
    test_tx();
    test_stuff();
    test_source();
    give_verdict();
  end

  // Watchdog: a hang counts as a failure
  initial begin
    repeat (20000) @(posedge sys_clk);
    fail_count++;
    $display("CHECK FAILED at %0t: run timed out", $time);
    give_verdict();
  end
endmodule
